/* hw/axis_homing_fsm.sv */
// Homing sequence of one axis, types B and C
module axis_homing_fsm
  import homing_pkg::*;
#(
  parameter int SW = 16
) (
  input  wire logic          ref_clk,   // System clock
  input  wire logic          rst_b,     // Async reset, active low
  input  wire logic          start,     // Begin a return
  input  wire logic          abort,     // Stop and drop the return
  input  wire logic          home_en,   // Machine zero present
  input  wire logic          pol,       // Slowdown polarity
  input  wire logic          dir_neg,   // Return toward negative
  input  wire logic          type_c,    // Type C when set
  input  wire logic          shared,    // One switch for both
  input  wire logic          slow_raw,  // Slowdown pin level
  input  wire logic          zero_raw,  // Zero pulse pin level
  input  wire logic [SW-1:0] lo_spd,    // Creep speed
  input  wire logic [SW-1:0] hi_spd,    // Approach speed
  output logic               move,      // Axis commanded to move
  output logic               move_neg,  // Motion is negative
  output logic      [SW-1:0] speed,     // Commanded speed
  output logic               done,      // Pulse at completion
  output logic               busy       // Return under way
);

  axis_state_t   st_r, st_nxt;
  logic          zlev_r;
  logic          slow;
  logic          fin;

  // High pin level means connected to 24V
  assign slow = pol ? slow_raw : ~slow_raw;

  //------------------------------------------------------------
  // Next state
  //------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    fin    = 1'b0;
    case (st_r)
      ST_IDLE:
        if (start && !home_en)
          fin = 1'b1;
        else if (start)
          st_nxt = ST_FAST;
      ST_FAST:
        if (slow)
          st_nxt = type_c ? ST_PASS : ST_CREEP;
      ST_CREEP:
        if (!slow)
          st_nxt = ST_SEEK;
      ST_SEEK:
        if (shared ? slow : (zero_raw != zlev_r))
        begin
          fin    = 1'b1;
          st_nxt = ST_IDLE;
        end
      ST_PASS:
        if (!slow)
          st_nxt = ST_STOP;
      ST_STOP:
        st_nxt = ST_BACK;
      ST_BACK:
        if (slow)
          st_nxt = ST_BACK_ON;
      ST_BACK_ON:
        if (!slow && shared)
        begin
          fin    = 1'b1;
          st_nxt = ST_IDLE;
        end
        else if (!slow)
          st_nxt = ST_SEEK;
      default:
        st_nxt = ST_IDLE;
    endcase
    if (abort)
    begin
      st_nxt = ST_IDLE;
      fin    = 1'b0;
    end
  end

  //------------------------------------------------------------
  // State, zero level reference and motion outputs
  //------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r     <= ST_IDLE;
      zlev_r   <= 1'b0;
      move     <= 1'b0;
      move_neg <= 1'b0;
      speed    <= '0;
      done     <= 1'b0;
    end
    else
    begin
      st_r     <= st_nxt;
      zlev_r   <= (st_nxt == ST_SEEK && st_r != ST_SEEK) ? zero_raw : zlev_r;
      move     <= st_nxt != ST_IDLE && st_nxt != ST_STOP;
      move_neg <= (st_nxt == ST_BACK || st_nxt == ST_BACK_ON ||
                   st_nxt == ST_SEEK && type_c) ? ~dir_neg : dir_neg;
      speed    <= (st_nxt == ST_FAST || st_nxt == ST_PASS) ? hi_spd :
                  (st_nxt == ST_IDLE || st_nxt == ST_STOP) ? '0 : lo_spd;
      done     <= fin;
    end
  end

  assign busy = st_r != ST_IDLE;

endmodule : axis_homing_fsm

/* hw/homing_pkg.sv */
// Types shared by the homing sequencer modules
package homing_pkg;

  typedef enum logic [3:0] {
    ST_IDLE,     // Waiting for a start
    ST_FAST,     // High speed approach
    ST_CREEP,    // Low speed on the slowdown switch
    ST_SEEK,     // Off the switch, watching for zero, or for the switch again when shared
    ST_PASS,     // Type C: crossing the switch at high speed
    ST_STOP,     // Type C: brought to rest before reversing
    ST_BACK,     // Type C: reversed, low speed, off the switch
    ST_BACK_ON   // Type C: second contact with the switch
  } axis_state_t;

endpackage : homing_pkg

/* hw/homing_regs.svh */
// Offsets, field positions and reset values of the homing sequencer
`ifndef HOMING_REGS_SVH
`define HOMING_REGS_SVH

//------------------------------------------------------------
// Register byte offsets
//------------------------------------------------------------
`define OFF_SLOW_STAT  12'h000
`define OFF_ZERO_STAT  12'h004
`define OFF_TYPE_SEL   12'h008
`define OFF_SHARED_SEL 12'h00C
`define OFF_KEY_OPT    12'h010
`define OFF_HOME_EN    12'h014
`define OFF_POLARITY   12'h018
`define OFF_DIRECTION  12'h01C
`define OFF_HOME_STAT  12'h020
`define OFF_IRQ_STAT   12'h024
`define OFF_IRQ_MASK   12'h028
`define OFF_CONTROL    12'h02C
`define OFF_LOW_SPD    12'h040
`define OFF_HIGH_SPD   12'h060
`define OFF_ZERO_OFS   12'h080
`define OFF_MACH_POS   12'h0A0
`define OFF_REF_PT     12'h100

//------------------------------------------------------------
// Field positions and reset values
//------------------------------------------------------------
`define KEY_LATCH_BIT  0
`define RAPID_OK_BIT   1
`define BUSY_LSB       8
`define RST_BITS       8'h00
`define RST_SPEED      16'h0000
`define RST_WORD       32'h0000_0000

`endif

/* hw/irq_sticky.sv */
// Sticky W1C flags masked onto one interrupt
module irq_sticky
  import homing_pkg::*;
#(
  parameter int W = 5
) (
  input  wire logic         ref_clk,  // System clock
  input  wire logic         rst_b,    // Async reset, active low
  input  wire logic [W-1:0] event_in, // One-cycle event pulses
  input  wire logic [W-1:0] clr_in,   // Write-one-to-clear strobes
  input  wire logic [W-1:0] mask_in,  // Enable per flag
  output logic      [W-1:0] flags,    // Sticky flags
  output logic              irq       // Level interrupt
);

  logic [W-1:0] flag_r;
  logic [W-1:0] flag_nxt;

  // Set beats clear so an event in the clearing cycle survives
  assign flag_nxt = (flag_r & ~clr_in) | event_in;
  assign flags    = flag_r;
  assign irq      = |(flag_r & mask_in);

  //------------------------------------------------------------
  // Flag storage
  //------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      flag_r <= '0;
    else
      flag_r <= flag_nxt;
  end

endmodule : irq_sticky

/* hw/machine_zero_return_sequencer.sv */
// Five-axis machine zero return sequencer with APB register file
//
// Behaviour
// - Enable bit clear: return ignores switch inputs
// - Polarity bit picks slowdown at 24V or open
// - Direction bit set returns in negative direction
// - Low speed register drives creep after slowdown
// - High speed register drives fast approach
// - Zero offset applied to final position
// - Four reference point coordinates per axis
// - Switch and zero inputs readable as status
// - Type B separate: slow, release, stop on change
// - Type B shared: contact slows, second contact stops
// - Type C: pass, stop, reverse, search second pass
`include "homing_regs.svh"
module machine_zero_return_sequencer
  import homing_pkg::*;
#(
  parameter int NAX = 5,  // Number of axes
  parameter int SW  = 16, // Speed word width
  parameter int NRP = 4   // Reference points per axis
) (
  input  wire logic                ref_clk,              // 20 MHz clock
  input  wire logic                rst_b,                // Async reset, active low
  input  wire logic [11:0]         paddr,                // APB address
  input  wire logic                psel,                 // APB select
  input  wire logic                penable,              // APB enable
  input  wire logic                pwrite,               // APB write
  input  wire logic [31:0]         pwdata,               // APB write data
  output logic      [31:0]         prdata,               // APB read data
  output logic                     pready,               // APB ready
  output logic                     pslverr,              // APB error
  input  wire logic                x_slowdown_input,     // X slowdown switch
  input  wire logic                y_slowdown_input,     // Y slowdown switch
  input  wire logic                z_slowdown_input,     // Z slowdown switch
  input  wire logic                fourth_slowdown_input,// 4th slowdown switch
  input  wire logic                fifth_slowdown_input, // 5th slowdown switch
  input  wire logic                x_zero_pulse,         // X zero pulse
  input  wire logic                y_zero_pulse,         // Y zero pulse
  input  wire logic                z_zero_pulse,         // Z zero pulse
  input  wire logic                fourth_zero_pulse,    // 4th zero pulse
  input  wire logic                fifth_zero_pulse,     // 5th zero pulse
  input  wire logic                home_mode,            // Zero return mode chosen
  input  wire logic [NAX-1:0]      home_key,             // Direction key per axis
  output logic      [NAX-1:0]      axis_move,            // Move command
  output logic      [NAX-1:0]      axis_dir_neg,         // Move is negative
  output logic      [NAX-1:0][SW-1:0] axis_speed,        // Speed command
  output logic      [NAX-1:0]      homed_lamp,           // Zero complete lamp
  output logic      [NAX-1:0]      rapid_ok,             // Manual rapid permitted
  output logic                     irq                   // Interrupt, active high
);

  //------------------------------------------------------------
  // Pin gathering
  //------------------------------------------------------------
  logic [NAX-1:0] slow_pin;
  logic [NAX-1:0] zero_pin;

  // Each axis has its own slowdown and zero input
  assign slow_pin = {fifth_slowdown_input, fourth_slowdown_input,
                     z_slowdown_input, y_slowdown_input,
                     x_slowdown_input};
  assign zero_pin = {fifth_zero_pulse, fourth_zero_pulse, z_zero_pulse,
                     y_zero_pulse, x_zero_pulse};

  //------------------------------------------------------------
  // Register storage
  //------------------------------------------------------------
  logic [7:0]     type_sel_r;
  logic [7:0]     shared_sel_r;
  logic [7:0]     key_opt_r;
  logic [7:0]     home_en_r;
  logic [7:0]     polarity_r;
  logic [7:0]     direction_r;
  logic [NAX-1:0] irq_mask_r;
  logic [NAX-1:0] homed_r;
  logic [NAX-1:0] key_q_r;
  logic [SW-1:0]  low_spd_r  [0:NAX-1];
  logic [SW-1:0]  high_spd_r [0:NAX-1];
  logic [31:0]    zero_ofs_r [0:NAX-1];
  logic [31:0]    mach_pos_r [0:NAX-1];
  logic [31:0]    ref_pt_r   [0:NAX*NRP-1];

  //------------------------------------------------------------
  // APB decode
  //------------------------------------------------------------
  logic        wr_en;
  logic        rd_en;
  logic [2:0]  ax_idx;
  logic        ax_ok;
  logic [4:0]  rp_idx;
  logic        rp_ok;
  logic        hit_slow, hit_zero, hit_type, hit_shared, hit_key;
  logic        hit_en, hit_pol, hit_dir, hit_hstat, hit_istat;
  logic        hit_imask, hit_ctrl, hit_low, hit_high, hit_ofs;
  logic        hit_pos, hit_ref, hit_any;

  // Access phase only
  assign wr_en  = psel && penable && pwrite;
  assign rd_en  = psel && penable && !pwrite;
  assign ax_idx = paddr[4:2];
  assign ax_ok  = ax_idx < 3'(NAX);
  assign rp_idx = paddr[6:2];
  assign rp_ok  = rp_idx < 5'(NAX * NRP);

  assign hit_slow   = paddr == `OFF_SLOW_STAT;
  assign hit_zero   = paddr == `OFF_ZERO_STAT;
  assign hit_type   = paddr == `OFF_TYPE_SEL;
  assign hit_shared = paddr == `OFF_SHARED_SEL;
  assign hit_key    = paddr == `OFF_KEY_OPT;
  assign hit_en     = paddr == `OFF_HOME_EN;
  assign hit_pol    = paddr == `OFF_POLARITY;
  assign hit_dir    = paddr == `OFF_DIRECTION;
  assign hit_hstat  = paddr == `OFF_HOME_STAT;
  assign hit_istat  = paddr == `OFF_IRQ_STAT;
  assign hit_imask  = paddr == `OFF_IRQ_MASK;
  assign hit_ctrl   = paddr == `OFF_CONTROL;
  assign hit_low    = (paddr & 12'hFE0) == `OFF_LOW_SPD && ax_ok;
  assign hit_high   = (paddr & 12'hFE0) == `OFF_HIGH_SPD && ax_ok;
  assign hit_ofs    = (paddr & 12'hFE0) == `OFF_ZERO_OFS && ax_ok;
  assign hit_pos    = (paddr & 12'hFE0) == `OFF_MACH_POS && ax_ok;
  assign hit_ref    = (paddr & 12'hF80) == `OFF_REF_PT && rp_ok;
  assign hit_any    = hit_slow | hit_zero | hit_type | hit_shared |
                      hit_key | hit_en | hit_pol | hit_dir | hit_hstat |
                      hit_istat | hit_imask | hit_ctrl | hit_low |
                      hit_high | hit_ofs | hit_pos | hit_ref;

  // Zero-wait slave; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit_any;

  //------------------------------------------------------------
  // Homing control derived from registers and keys
  //------------------------------------------------------------
  logic           key_latch;
  logic [NAX-1:0] busy;
  logic [NAX-1:0] done;
  logic [NAX-1:0] start;
  logic [NAX-1:0] abort;
  logic [NAX-1:0] sw_abort;
  logic [NAX-1:0] irq_flags;

  assign key_latch = key_opt_r[`KEY_LATCH_BIT];
  assign sw_abort  = (wr_en && hit_ctrl) ? pwdata[NAX-1:0] : '0;
  // Key press starts an idle axis in zero mode
  assign start     = home_key & ~key_q_r & ~busy & {NAX{home_mode}};
  // Without latching, letting go of the key drops the return
  assign abort     = sw_abort | (busy & ~home_key & {NAX{~key_latch}}) |
                     (busy & {NAX{~home_mode}});
  // Rapid traverse before homing only when permitted
  assign rapid_ok  = homed_r |
                     {NAX{key_opt_r[`RAPID_OK_BIT]}};
  assign homed_lamp = homed_r;

  //------------------------------------------------------------
  // Per-axis sequencers
  //------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NAX; g = g + 1)
    begin : g_axis
      axis_homing_fsm #(
        .SW (SW)
      ) u_fsm (
        .ref_clk  (ref_clk),
        .rst_b    (rst_b),
        .start    (start[g]),
        .abort    (abort[g]),
        .home_en  (home_en_r[g]),
        .pol      (polarity_r[g]),
        .dir_neg  (direction_r[g]),
        .type_c   (type_sel_r[g]),
        .shared   (shared_sel_r[g]),
        .slow_raw (slow_pin[g]),
        .zero_raw (zero_pin[g]),
        .lo_spd   (low_spd_r[g]),
        .hi_spd   (high_spd_r[g]),
        .move     (axis_move[g]),
        .move_neg (axis_dir_neg[g]),
        .speed    (axis_speed[g]),
        .done     (done[g]),
        .busy     (busy[g])
      );

      // Completion loads the offset as the machine position
      always_ff @(posedge ref_clk or negedge rst_b)
      begin
        if (!rst_b)
          mach_pos_r[g] <= `RST_WORD;
        else if (done[g])
          mach_pos_r[g] <= zero_ofs_r[g];
      end

      // Homed flag clears when a new return begins; a completion in the same cycle wins
      always_ff @(posedge ref_clk or negedge rst_b)
      begin
        if (!rst_b)
          homed_r[g] <= 1'b0;
        else if (done[g])
          homed_r[g] <= 1'b1;
        else if (start[g])
          homed_r[g] <= 1'b0;
      end
    end
  endgenerate

  //------------------------------------------------------------
  // Completion events and interrupt
  //------------------------------------------------------------
  irq_sticky #(
    .W (NAX)
  ) u_irq (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .event_in (done),
    .clr_in   ((wr_en && hit_istat) ? pwdata[NAX-1:0] : '0),
    .mask_in  (irq_mask_r),
    .flags    (irq_flags),
    .irq      (irq)
  );

  //------------------------------------------------------------
  // Configuration bytes and key history
  //------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      type_sel_r   <= `RST_BITS;
      shared_sel_r <= `RST_BITS;
      key_opt_r    <= `RST_BITS;
      home_en_r    <= `RST_BITS;
      polarity_r   <= `RST_BITS;
      direction_r  <= `RST_BITS;
      irq_mask_r   <= '0;
      key_q_r      <= '0;
    end
    else
    begin
      key_q_r <= home_key;
      if (wr_en && hit_type)
        type_sel_r <= pwdata[7:0];
      if (wr_en && hit_shared)
        shared_sel_r <= pwdata[7:0];
      if (wr_en && hit_key)
        key_opt_r <= pwdata[7:0];
      if (wr_en && hit_en)
        home_en_r <= pwdata[7:0];
      if (wr_en && hit_pol)
        polarity_r <= pwdata[7:0];
      if (wr_en && hit_dir)
        direction_r <= pwdata[7:0];
      if (wr_en && hit_imask)
        irq_mask_r <= pwdata[NAX-1:0];
    end
  end

  //------------------------------------------------------------
  // Per-axis speed and offset words
  //------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < NAX; i++)
      begin
        low_spd_r[i]  <= `RST_SPEED;
        high_spd_r[i] <= `RST_SPEED;
        zero_ofs_r[i] <= `RST_WORD;
      end
    end
    else
    begin
      if (wr_en && hit_low)
        low_spd_r[ax_idx] <= pwdata[SW-1:0];
      if (wr_en && hit_high)
        high_spd_r[ax_idx] <= pwdata[SW-1:0];
      if (wr_en && hit_ofs)
        zero_ofs_r[ax_idx] <= pwdata;
    end
  end

  //------------------------------------------------------------
  // Reference point coordinates, axis-major, 0.001 mm units
  //------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < NAX * NRP; i++)
        ref_pt_r[i] <= `RST_WORD;
    end
    else if (wr_en && hit_ref)
      ref_pt_r[rp_idx] <= pwdata;
  end

  //------------------------------------------------------------
  // Read data
  //------------------------------------------------------------
  logic [31:0] rd_mux;
  logic [31:0] hstat;

  // Busy bits sit above the homed bits
  assign hstat = {16'h0, 3'b000, busy, 3'b000, homed_r};

  // Status reads show live pin levels, bits above zero
  assign rd_mux = hit_slow   ? {27'h0, slow_pin} :
                  hit_zero   ? {27'h0, zero_pin} :
                  hit_type   ? {24'h0, type_sel_r} :
                  hit_shared ? {24'h0, shared_sel_r} :
                  hit_key    ? {24'h0, key_opt_r} :
                  hit_en     ? {24'h0, home_en_r} :
                  hit_pol    ? {24'h0, polarity_r} :
                  hit_dir    ? {24'h0, direction_r} :
                  hit_hstat  ? hstat :
                  hit_istat  ? {27'h0, irq_flags} :
                  hit_imask  ? {27'h0, irq_mask_r} :
                  hit_low    ? {16'h0, low_spd_r[ax_idx]} :
                  hit_high   ? {16'h0, high_spd_r[ax_idx]} :
                  hit_ofs    ? zero_ofs_r[ax_idx] :
                  hit_pos    ? mach_pos_r[ax_idx] :
                  hit_ref    ? ref_pt_r[rp_idx] : 32'h0;

  // Read data loaded in setup, valid in access
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      prdata <= 32'h0;
    else if (psel && !penable && !pwrite)
      prdata <= rd_mux;
  end

endmodule : machine_zero_return_sequencer

/* test/homing_switch_model.sv */
// Far-side model: slowdown switches and zero pulses
module homing_switch_model (
  input  wire logic       ref_clk,   // Clock
  input  wire logic       rst_b,     // Reset, active low
  input  wire logic [4:0] axis_move, // Motion per axis
  input  wire logic [4:0] dir_neg,   // Negative motion
  input  wire logic [4:0] pol,       // Pin high means slowdown
  output logic      [4:0] slow_pin,  // Slowdown pins
  output logic      [4:0] zero_pin   // Zero pulse pins
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0][5:0] pos_r;
  // One step per moving cycle
  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
      pos_r <= '0;
    else
      for (int i = 0; i < 5; i++)
        if (axis_move[i])
          pos_r[i] <= dir_neg[i] ? pos_r[i] - 6'd1 : pos_r[i] + 6'd1;
  // Dogs both sides; short dog is the type B shared second contact
  always_comb
    for (int i = 0; i < 5; i++)
    begin
      slow_pin[i] = (pos_r[i] inside {[4:7], [12:13], [56:59], [50:51]}) ~^ pol[i];
      zero_pin[i] = pos_r[i][1];
    end
endmodule : homing_switch_model

/* test/machine_zero_return_sequencer_chk.sv */
// Port assertions of the homing sequencer
module homing_chk #(
  parameter int NAX = 5, // Axes
  parameter int SW  = 16 // Speed width
) (
  input wire logic                   ref_clk,      // Clock
  input wire logic                   rst_b,        // Reset, active low
  input wire logic                   psel,         // APB select
  input wire logic                   penable,      // APB enable
  input wire logic                   pwrite,       // APB write
  input wire logic [31:0]            prdata,       // APB read data
  input wire logic                   pready,       // APB ready
  input wire logic                   pslverr,      // APB error
  input wire logic                   home_mode,    // Zero return mode
  input wire logic [NAX-1:0]         axis_move,    // Move command
  input wire logic [NAX-1:0]         axis_dir_neg, // Negative motion
  input wire logic [NAX-1:0][SW-1:0] axis_speed,   // Speed command
  input wire logic [NAX-1:0]         homed_lamp,   // Zero complete lamp
  input wire logic [NAX-1:0]         rapid_ok      // Rapid permitted
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence s_access;
    psel && penable;
  endsequence
  // Bus answers and rapid permission
  a_ready_high: assert property (s_access |-> pready) else $error("pready low");
  a_error_phase: assert property (pslverr |-> s_access) else $error("stray pslverr");
  a_refused_read: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read data");
  a_rapid_homed: assert property ((homed_lamp & ~rapid_ok) == '0)
    else $error("homed without rapid");
  // Per-axis motion
  for (genvar i = 0; i < NAX; i++)
  begin : g_ax
    sequence s_pause;
      $fell(axis_move[i]) ##1 axis_move[i];
    endsequence
    a_idle_speed: assert property (!axis_move[i] |-> axis_speed[i] == '0)
      else $error("idle speed");
    a_start_mode: assert property ($rose(axis_move[i]) |-> $past(home_mode))
      else $error("move without mode");
    a_dir_steady: assert property (axis_move[i] ##1 axis_move[i]
      |-> $stable(axis_dir_neg[i])) else $error("dir changed");
    a_lamp_rest: assert property ($rose(homed_lamp[i])
      |-> !axis_move[i] && !$past(axis_move[i])) else $error("lamp in motion");
    a_stop_reverse: assert property (s_pause
      |-> axis_dir_neg[i] != $past(axis_dir_neg[i], 2)) else $error("no reversal");
  end
endmodule : homing_chk

bind machine_zero_return_sequencer homing_chk #(.NAX(NAX), .SW(SW)) homing_chk_inst (
  .ref_clk, .rst_b, .psel, .penable, .pwrite, .prdata, .pready, .pslverr, .home_mode,
  .axis_move, .axis_dir_neg, .axis_speed, .homed_lamp, .rapid_ok);

/* test/tb_machine_zero_return_sequencer.sv */
// Self-checking bench of the homing sequencer
`include "homing_regs.svh"
module tb_machine_zero_return_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [11:0] a; logic [31:0] d, e; logic err;} row_t;
  logic            ref_clk, rst_b, psel, penable, pwrite, pready, pslverr, irq, home_mode, slv;
  logic [11:0]     paddr;
  logic [31:0]     pwdata, prdata, rd;
  logic [4:0]      home_key, axis_move, axis_dir_neg, homed_lamp, rapid_ok, slow, zero, pol_v;
  logic [4:0][15:0] axis_speed;
  int              errors, n_checks, cyc;
  bit              msk;
  row_t rows[] = '{'{`OFF_TYPE_SEL, 32'h15, 32'h15, 0},
    '{`OFF_SHARED_SEL, 32'hA, 32'hA, 0}, '{`OFF_KEY_OPT, 32'h3, 32'h3, 0},
    '{`OFF_HOME_EN, 32'hA, 32'hA, 0}, '{`OFF_POLARITY, 32'h15, 32'h15, 0},
    '{`OFF_DIRECTION, 32'h13, 32'h13, 0}, '{`OFF_IRQ_MASK, 32'h1F, 32'h1F, 0},
    '{`OFF_LOW_SPD + 12'h004, 32'h1234, 32'h1234, 0},
    '{`OFF_ZERO_OFS + 12'h010, 32'h8765_4321, 32'h8765_4321, 0},
    '{`OFF_REF_PT + 12'h03C, 32'h1_E240, 32'h1_E240, 0},
    '{`OFF_HOME_STAT, 32'h1F, 32'h0, 0}, '{`OFF_MACH_POS, 32'h5, 32'h0, 0},
    '{`OFF_CONTROL, 32'h1F, 32'h0, 0}, '{12'hFFC, 32'h5A5A, 32'h0, 1}};
  machine_zero_return_sequencer machine_zero_return_sequencer_inst (
    .ref_clk, .rst_b, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .x_slowdown_input(slow[0]), .y_slowdown_input(slow[1]), .z_slowdown_input(slow[2]),
    .fourth_slowdown_input(slow[3]), .fifth_slowdown_input(slow[4]), .x_zero_pulse(zero[0]),
    .y_zero_pulse(zero[1]), .z_zero_pulse(zero[2]), .fourth_zero_pulse(zero[3]),
    .fifth_zero_pulse(zero[4]), .home_mode, .home_key, .axis_move, .axis_dir_neg,
    .axis_speed, .homed_lamp, .rapid_ok, .irq);
  homing_switch_model homing_switch_model_inst (.ref_clk, .rst_b, .axis_move,
    .dir_neg(axis_dir_neg), .pol(pol_v), .slow_pin(slow), .zero_pin(zero));
  // 20 MHz clock and cycle ceiling
  initial
  begin
    ref_clk = 0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // One APB transfer, idle edge first
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge ref_clk) psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk) penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // One zero return on axis a
  task automatic home(int a, bit en, bit tc, bit sh, bit dn, bit pl);
    bit hi_seen, lo_seen, dok, hi;
    {hi_seen, lo_seen, dok} = 3'b000;
    apb(1, `OFF_HOME_EN, 32'h1F ^ (32'(!en) << a));
    apb(1, `OFF_TYPE_SEL, 32'(tc) << a);
    apb(1, `OFF_SHARED_SEL, 32'(sh) << a);
    apb(1, `OFF_DIRECTION, 32'(dn) << a);
    apb(1, `OFF_POLARITY, 32'(pl) << a);
    pol_v <= 5'(pl) << a;
    home_key[a] <= 1'b1;
    @(posedge ref_clk) home_key[a] <= 1'b0;
    repeat (2) @(negedge ref_clk);
    for (int i = 0; i < 400 && homed_lamp[a] !== 1'b1; i++)
    begin
      @(negedge ref_clk);
      hi = axis_move[a] === 1'b1 && axis_speed[a] === 16'h0100 + 16'(a);
      hi_seen |= hi;
      dok |= hi && axis_dir_neg[a] === dn;
      lo_seen |= axis_move[a] === 1'b1 && axis_speed[a] === 16'h0010 + 16'(a);
    end
    chk("fast", hi_seen, en);
    chk("creep", lo_seen, en);
    chk("dir", dok, en);
    chk("lamp", homed_lamp[a], 1);
    apb(0, `OFF_IRQ_STAT, 0);
    chk("flag", rd, 32'(1) << a);
    chk("irq", irq, msk);
    apb(1, `OFF_IRQ_STAT, 32'(1) << a);
    repeat (2) @(negedge ref_clk);
    chk("irq clear", irq, 0);
    apb(0, `OFF_MACH_POS + 12'(4 * a), 0);
    if (en)
      chk("position", rd, 32'h0001_0000 + 32'(a));
    $display("homing axis %0d done", a);
  endtask : home
  initial
  begin
    {psel, penable, pwrite, home_mode, paddr, pwdata, home_key, pol_v} = '0;
    {errors, n_checks, cyc, rst_b, msk} = '0;
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    apb(0, `OFF_SLOW_STAT, 0);
    chk("slow status", rd, 32'h1F);
    apb(0, `OFF_ZERO_STAT, 0);
    chk("zero status", rd, 32'h0);
    // Register rows
    foreach (rows[i])
    begin
      apb(0, rows[i].a, 0);
      chk("reset", rd, 32'h0);
      apb(1, rows[i].a, rows[i].d);
      chk("wr err", slv, rows[i].err);
      apb(0, rows[i].a, 0);
      chk("readback", rd, rows[i].e);
      chk("rd err", slv, rows[i].err);
    end
    $display("register rows done");
    for (int a = 0; a < 5; a++)
    begin
      apb(1, `OFF_LOW_SPD + 12'(4 * a), 32'h0010 + 32'(a));
      apb(1, `OFF_HIGH_SPD + 12'(4 * a), 32'h0100 + 32'(a));
      apb(1, `OFF_ZERO_OFS + 12'(4 * a), 32'h0001_0000 + 32'(a));
    end
    apb(1, `OFF_KEY_OPT, 32'h1);
    apb(1, `OFF_IRQ_MASK, 32'h1F);
    msk = 1;
    home_mode <= 1'b1;
    chk("rapid before", rapid_ok, 0);
    home(0, 1, 0, 0, 0, 0);
    home(1, 1, 0, 0, 1, 1);
    home(2, 1, 0, 1, 0, 0);
    home(3, 1, 1, 0, 0, 0);
    home(4, 1, 1, 1, 0, 0);
    apb(1, `OFF_IRQ_MASK, 32'h0);
    msk = 0;
    home(0, 0, 0, 0, 0, 0);
    chk("rapid after", rapid_ok, 5'h1F);
    results();
  end
endmodule : tb_machine_zero_return_sequencer
